// ### logic/accel_regs_pkg.sv
package accel_regs_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_RATE        = 8'h2c;
    localparam logic [7:0] IDX_POWER       = 8'h2d;
    localparam logic [7:0] IDX_IRQ_EN      = 8'h2e;
    localparam logic [7:0] IDX_IRQ_MAP     = 8'h2f;
    localparam logic [7:0] IDX_CAUSE       = 8'h30;
    localparam logic [7:0] IDX_FORMAT      = 8'h31;
    localparam logic [7:0] IDX_AXIS_DATA   = 8'h32;
    localparam logic [7:0] IDX_LINK_STATUS = 8'h40;

    // ------------------------------------------------------------
    // writable-bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RATE_MASK   = 8'h1f;
    localparam logic [7:0] POWER_MASK  = 8'h3f;
    localparam logic [7:0] FORMAT_MASK = 8'hef;
    localparam logic [7:0] RATE_RST    = 8'h0a;
    localparam logic [7:0] POWER_RST   = 8'h00;
    localparam logic [7:0] IRQ_EN_RST  = 8'h00;
    localparam logic [7:0] IRQ_MAP_RST = 8'h00;
    localparam logic [7:0] FORMAT_RST  = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RATE_LOWPWR  = 4;
    localparam int PWR_LINK     = 5;
    localparam int PWR_AUTO     = 4;
    localparam int PWR_MEASURE  = 3;
    localparam int PWR_SLEEP    = 2;
    localparam int FMT_SELFTEST = 7;
    localparam int FMT_3WIRE    = 6;
    localparam int FMT_INVERT   = 5;
    localparam int FMT_FULLRES  = 3;
    localparam int FMT_JUSTIFY  = 2;
    localparam int CS_DREADY    = 7;
    localparam int CS_ACT       = 4;
    localparam int CS_INACT     = 3;
    localparam int CS_WMARK     = 1;
    localparam int CS_OVR       = 0;

    // clear masks: data read vs cause read
    localparam logic [7:0] DATA_CLR_MASK  = 8'h82;
    localparam logic [7:0] CAUSE_CLR_MASK = 8'h7c;

    // ------------------------------------------------------------
    // sample formatting and sleep rate
    // ------------------------------------------------------------
    localparam int         RAW_W         = 13;
    localparam logic [3:0] BASE_W        = 4'd10;
    localparam logic [3:0] FULL_W        = 4'd13;
    localparam logic [4:0] OUT_W         = 5'd16;
    localparam logic [3:0] SLEEP_BASE_HZ = 4'd8;
    localparam logic [2:0] HSIZE_WORD    = 3'b010;

    typedef enum logic [0:0] {LNK_WAIT_INACT, LNK_WAIT_ACT} link_state_t;

endpackage

// ### logic/accel_power_irq_format_regs.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Function
// - low-power bit selects reduced power operation
// - rate field resets to 100 Hz code
// - samples dropped, never stalled, when host busy
// - linked mode alternates inactivity then activity detection
// - unlinked: activity and inactivity run concurrently
// - link plus autosleep sleeps on inactivity, wakes
// - measure bit: standby or measuring; reset standby
// - sleep: no ready, no FIFO, activity only
// - wakeup field picks 8, 4, 2, 1 Hz
// - enables gate only the interrupt output
// - routing bit picks pin; pins OR interrupts
// - ready, watermark cleared by data read; overrun too unless orient mode
// - other cause bits, and overrun in orient mode, cleared by cause read
// - clip samples except in full-resolution 16 g range
// - self-test bit applies test force
// - wiring bit selects three or four wire
// - polarity bit makes pins active low
// - full resolution keeps 4 mg scale
// - justify bit: left aligned or sign extended
// - range field selects 2, 4, 8, 16 g
module accel_power_irq_format_regs
    import accel_regs_pkg::*;
(
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    input  wire logic                   serial_sclk,
    input  wire logic                   serial_cs_n,
    input  wire logic                   sample_strobe,
    input  wire logic signed [RAW_W-1:0] raw_accel,
    input  wire logic                   act_func_en,
    input  wire logic                   inact_func_en,
    input  wire logic                   orient_mode,
    input  wire logic                   evt_single_tap,
    input  wire logic                   evt_double_tap,
    input  wire logic                   evt_activity,
    input  wire logic                   evt_inactivity,
    input  wire logic                   evt_free_fall,
    input  wire logic                   evt_watermark,
    input  wire logic                   evt_overrun,
    output logic                        irq_pin_a,
    output logic                        irq_pin_b,
    output logic                        low_power_mode,
    output logic [3:0]                  odr_code,
    output logic                        measure_active,
    output logic                        sleep_active,
    output logic [3:0]                  sleep_rate_hz,
    output logic                        act_det_en,
    output logic                        inact_det_en,
    output logic                        fifo_write_en,
    output logic                        self_test_force,
    output logic                        three_wire_mode
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // clip and place one sample as the format register asks
    function automatic logic [15:0] fmt_sample(
        input logic signed [RAW_W-1:0] raw,
        input logic [1:0]              rng,
        input logic                    full,
        input logic                    left
    );
        logic signed [RAW_W-1:0] v;
        logic signed [RAW_W-1:0] hi;
        logic signed [RAW_W-1:0] lo;
        logic [3:0]              w;
        logic [15:0]             ext;
        v   = full ? raw : (raw >>> rng);
        w   = full ? (BASE_W + {2'b00, rng}) : BASE_W;
        hi  = $signed((13'h0001 << (w - 4'd1)) - 13'h0001);
        lo  = -hi - 13'sd1;
        if (w != FULL_W) begin
            if (v > hi) begin
                v = hi;
            end else if (v < lo) begin
                v = lo;
            end
        end
        ext = {{(16 - RAW_W){v[RAW_W-1]}}, v};
        if (left) begin
            ext = ext << (OUT_W - {1'b0, w});
        end
        return ext;
    endfunction

    // reading frequency while asleep
    function automatic logic [3:0] sleep_hz(input logic [1:0] code);
        return SLEEP_BASE_HZ >> code;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  rate_r;
    logic [7:0]  power_r;
    logic [7:0]  irq_en_r;
    logic [7:0]  irq_map_r;
    logic [7:0]  cause_r;
    logic [7:0]  format_r;
    logic [15:0] sample_r;
    logic [3:0]  drop_cnt_r;
    logic        asleep_r;
    link_state_t lnk_r;
    logic        ph_wr_r;
    logic        ph_rd_r;
    logic        ph_ok_r;
    logic [7:0]  ph_idx_r;
    logic        rd_done_r;
    logic [31:0] hrdata_r;
    logic        pin_a_r;
    logic        pin_b_r;
    logic        sclk_s1_r;
    logic        sclk_s2_r;
    logic        sclk_s3_r;
    logic        csn_s1_r;
    logic        csn_s2_r;
    logic        busy_r;

    logic        wr_fire;
    logic        rd_fire;
    logic        rd_cause;
    logic        rd_data;
    logic        measure;
    logic        link_on;
    logic        linked_both;
    logic        sleep_eff;
    logic        sample_take;
    logic        sample_drop;
    logic        sclk_rise;
    logic        pend_a;
    logic        pend_b;
    logic [7:0]  wbyte;
    logic [7:0]  cause_set;
    logic [7:0]  cause_clr;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_r  <= 1'b0;
            ph_rd_r  <= 1'b0;
            ph_ok_r  <= 1'b0;
            ph_idx_r <= 8'h00;
        end else if (hready) begin
            ph_wr_r  <= hsel && htrans[1] && hwrite;
            ph_rd_r  <= hsel && htrans[1] && !hwrite;
            ph_ok_r  <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00) && (hsize == HSIZE_WORD);
            ph_idx_r <= haddr[9:2];
        end
    end

    // reads take one wait state so the data leave a flip-flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_done_r <= 1'b0;
        end else begin
            rd_done_r <= ph_rd_r && !rd_done_r;
        end
    end

    assign hreadyout = !(ph_rd_r && !rd_done_r);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign wr_fire   = ph_wr_r && ph_ok_r;
    assign rd_fire   = ph_rd_r && !rd_done_r && ph_ok_r;
    assign rd_cause  = rd_fire && (ph_idx_r == IDX_CAUSE);
    assign rd_data   = rd_fire && (ph_idx_r == IDX_AXIS_DATA);
    assign wbyte     = hwdata[7:0];

    // read multiplexer; unmapped reads as zero
    always_comb begin
        rd_mux = 32'h00000000;
        case (ph_idx_r)
            IDX_RATE:        rd_mux[7:0]  = rate_r;
            IDX_POWER:       rd_mux[7:0]  = power_r;
            IDX_IRQ_EN:      rd_mux[7:0]  = irq_en_r;
            IDX_IRQ_MAP:     rd_mux[7:0]  = irq_map_r;
            IDX_CAUSE:       rd_mux[7:0]  = cause_r;
            IDX_FORMAT:      rd_mux[7:0]  = format_r;
            IDX_AXIS_DATA:   rd_mux[15:0] = sample_r;
            IDX_LINK_STATUS: rd_mux[7:0]  = {drop_cnt_r, measure, sleep_eff, (lnk_r == LNK_WAIT_ACT), asleep_r};
            default:         rd_mux       = 32'h00000000;
        endcase
    end

    // read data register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (ph_rd_r && !rd_done_r) begin
            hrdata_r <= ph_ok_r ? rd_mux : 32'h00000000;
        end
    end

    // writable registers; fixed-zero bits masked off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_r    <= RATE_RST;
            power_r   <= POWER_RST;
            irq_en_r  <= IRQ_EN_RST;
            irq_map_r <= IRQ_MAP_RST;
            format_r  <= FORMAT_RST;
        end else if (wr_fire) begin
            case (ph_idx_r)
                IDX_RATE:    rate_r    <= wbyte & RATE_MASK;
                IDX_POWER:   power_r   <= wbyte & POWER_MASK;
                IDX_IRQ_EN:  irq_en_r  <= wbyte;
                IDX_IRQ_MAP: irq_map_r <= wbyte;
                IDX_FORMAT:  format_r  <= wbyte & FORMAT_MASK;
                default:     ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // serial link watch
    // ------------------------------------------------------------

    // two-stage synchronisers, third stage for edge finding
    // clock stages reset high so an idle-high clock gives no false rise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_s1_r <= 1'b1;
            sclk_s2_r <= 1'b1;
            sclk_s3_r <= 1'b1;
            csn_s1_r  <= 1'b1;
            csn_s2_r  <= 1'b1;
        end else begin
            sclk_s1_r <= serial_sclk;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            csn_s1_r  <= serial_cs_n;
            csn_s2_r  <= csn_s1_r;
        end
    end

    assign sclk_rise = sclk_s2_r && !sclk_s3_r;

    // transfer in progress from first rising clock edge until deselect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r <= 1'b0;
        end else if (csn_s2_r) begin
            busy_r <= 1'b0;
        end else if (sclk_rise) begin
            busy_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // power state and detection sequencing
    // ------------------------------------------------------------
    assign measure     = power_r[PWR_MEASURE];
    assign link_on     = power_r[PWR_LINK];
    assign linked_both = link_on && act_func_en && inact_func_en;
    assign sleep_eff   = power_r[PWR_SLEEP] || asleep_r;

    // linked mode alternates; restarts on inactivity watch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lnk_r <= LNK_WAIT_INACT;
        end else begin
            case (lnk_r)
                LNK_WAIT_INACT: begin
                    if (measure && linked_both && evt_inactivity) begin
                        lnk_r <= LNK_WAIT_ACT;
                    end
                end
                LNK_WAIT_ACT: begin
                    if (!measure || !linked_both) begin
                        lnk_r <= LNK_WAIT_INACT;
                    end else if (evt_activity) begin
                        lnk_r <= LNK_WAIT_INACT;
                    end
                end
                default: lnk_r <= LNK_WAIT_INACT;
            endcase
        end
    end

    // autosleep only with link; wake on activity
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            asleep_r <= 1'b0;
        end else if (!measure || !link_on || !power_r[PWR_AUTO]) begin
            asleep_r <= 1'b0;
        end else if (evt_activity && act_det_en) begin
            asleep_r <= 1'b0;
        end else if (evt_inactivity && inact_det_en) begin
            asleep_r <= 1'b1;
        end
    end

    // detection enables toward the detection functions
    assign act_det_en   = measure && act_func_en
                          && (sleep_eff || !linked_both || (lnk_r == LNK_WAIT_ACT));
    assign inact_det_en = measure && inact_func_en && !sleep_eff
                          && (!linked_both || (lnk_r == LNK_WAIT_INACT));

    // control levels toward the sensing core
    assign low_power_mode  = rate_r[RATE_LOWPWR];
    assign odr_code        = rate_r[3:0];
    assign measure_active  = measure;
    assign sleep_active    = sleep_eff;
    assign sleep_rate_hz   = sleep_hz(power_r[1:0]);
    assign fifo_write_en   = measure && !sleep_eff;
    assign self_test_force = format_r[FMT_SELFTEST];
    assign three_wire_mode = format_r[FMT_3WIRE];

    // ------------------------------------------------------------
    // sample capture
    // ------------------------------------------------------------
    assign sample_take = sample_strobe && measure && !busy_r;
    assign sample_drop = sample_strobe && measure && busy_r;

    // output data keep updating in sleep too
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_r <= 16'h0000;
        end else if (sample_take) begin
            sample_r <= fmt_sample(raw_accel, format_r[1:0], format_r[FMT_FULLRES], format_r[FMT_JUSTIFY]);
        end
    end

    // saturating count of discarded samples
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drop_cnt_r <= 4'h0;
        end else if (sample_drop && (drop_cnt_r != 4'hf)) begin
            drop_cnt_r <= drop_cnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // interrupt cause, routing and pins
    // ------------------------------------------------------------
    assign cause_set = {sample_take && !sleep_eff,
                        evt_single_tap, evt_double_tap, evt_activity,
                        evt_inactivity, evt_free_fall, evt_watermark, evt_overrun};
    assign cause_clr = (rd_data ? (DATA_CLR_MASK | {7'h00, !orient_mode}) : 8'h00)
                     | (rd_cause ? (CAUSE_CLR_MASK | {7'h00, orient_mode}) : 8'h00);

    // sticky causes, set beats clear, independent of enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause_r <= 8'h00;
        end else begin
            cause_r <= (cause_r & ~cause_clr) | cause_set;
        end
    end

    assign pend_a = |(cause_r & irq_en_r & ~irq_map_r);
    assign pend_b = |(cause_r & irq_en_r & irq_map_r);

    // pin drivers with selectable polarity
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_a_r <= 1'b0;
            pin_b_r <= 1'b0;
        end else begin
            pin_a_r <= pend_a ^ format_r[FMT_INVERT];
            pin_b_r <= pend_b ^ format_r[FMT_INVERT];
        end
    end

    assign irq_pin_a = pin_a_r;
    assign irq_pin_b = pin_b_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_power_wr_meas;
        wr_fire && (ph_idx_r == IDX_POWER) && hwdata[PWR_MEASURE];
    endsequence

    sequence s_fmt_wr;
        wr_fire && (ph_idx_r == IDX_FORMAT);
    endsequence

    AST_MEASURE_ON: assert property (@(posedge hclk) disable iff (!hresetn)
        s_power_wr_meas |=> measure_active)
        else $error("measure write did not enter measurement");

    AST_RATE_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(hresetn) |-> (odr_code == RATE_RST[3:0]))
        else $error("rate code not at default after reset");

    AST_FMT_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        s_fmt_wr |=> !format_r[4] && (format_r[3:0] == $past(hwdata[3:0])))
        else $error("format write stored wrongly");

    AST_LINK_SWAP: assert property (@(posedge hclk) disable iff (!hresetn)
        (measure && linked_both && !sleep_eff && (lnk_r == LNK_WAIT_INACT) && evt_inactivity
         && !wr_fire && !asleep_r && !power_r[PWR_AUTO])
        |=> !linked_both || (act_det_en && !inact_det_en))
        else $error("linked mode did not switch to activity watch");

    AST_SLEEP_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
        sleep_eff |-> !fifo_write_en && !inact_det_en && !(sample_take && cause_set[CS_DREADY]))
        else $error("sleep did not gate ready, fifo or inactivity");

    AST_AUTOSLEEP: assert property (@(posedge hclk) disable iff (!hresetn)
        (measure && link_on && power_r[PWR_AUTO] && inact_det_en && evt_inactivity
         && !evt_activity && !wr_fire) |=> sleep_active)
        else $error("autosleep did not enter sleep");

    AST_PIN_A: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 (irq_pin_a == ($past(pend_a) ^ $past(format_r[FMT_INVERT]))))
        else $error("pin a does not follow routed causes");

    AST_CAUSE_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_cause && !evt_activity && !evt_inactivity) |=> !cause_r[CS_ACT] && !cause_r[CS_INACT])
        else $error("cause read did not clear event bits");

    AST_DATA_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_data && !sample_take && !evt_watermark) ##1 1'b1 |-> !cause_r[CS_DREADY] && !cause_r[CS_WMARK])
        else $error("data read did not clear ready or watermark");

    AST_DROP: assert property (@(posedge hclk) disable iff (!hresetn)
        (sample_drop && (drop_cnt_r != 4'hf)) |=> (drop_cnt_r == $past(drop_cnt_r) + 4'h1) && $stable(sample_r))
        else $error("busy-link sample not discarded");

endmodule

// ### sim/serial_host_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// host side of the serial link
// ------------------------------------------------------------
module serial_host_model (
    input  wire logic go,
    output logic      sclk,
    output logic      cs_n
);
    // clock idles high and toggles only inside a frame
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        forever begin
            @(posedge go);
            cs_n = 1'b0;
            repeat (8) begin
                #160 sclk = 1'b0;
                #160 sclk = 1'b1;
            end
            #160 cs_n = 1'b1;
        end
    end
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps

module testbench
    import accel_regs_pkg::*;
;
    typedef struct {logic [7:0] i; logic [7:0] w; logic [7:0] e;} row_t;
    logic        hclk, hresetn, hsel, hwrite, go, sclk, cs_n, rdyo, pa, pb, lp, ms, st, tw;
    logic        fa, fi, hr, sa, fw, ad, id;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  stim;
    logic [3:0]  odr, shz;
    logic signed [RAW_W-1:0] raw;
    int          fail_count, samples_checked;
    // write then read back; map before enable
    row_t rows[8] = '{'{IDX_RATE, 8'hff, 8'h1f}, '{IDX_RATE, 8'h1a, 8'h1a}, '{IDX_POWER, 8'hff, 8'h3f},
        '{IDX_IRQ_MAP, 8'h00, 8'h00}, '{IDX_IRQ_EN, 8'h10, 8'h10}, '{IDX_FORMAT, 8'hff, 8'hef},
        '{IDX_CAUSE, 8'hff, 8'h00}, '{8'h20, 8'hff, 8'h00}};

    serial_host_model host (.go(go), .sclk(sclk), .cs_n(cs_n));
    accel_power_irq_format_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdyo),
        .hreadyout(rdyo), .hresp(hr), .hrdata(hrdata), .serial_sclk(sclk), .serial_cs_n(cs_n),
        .sample_strobe(stim[7]), .raw_accel(raw), .act_func_en(fa), .inact_func_en(fi),
        .orient_mode(1'b0), .evt_single_tap(stim[6]), .evt_double_tap(stim[5]), .evt_activity(stim[4]),
        .evt_inactivity(stim[3]), .evt_free_fall(stim[2]), .evt_watermark(stim[1]), .evt_overrun(stim[0]),
        .irq_pin_a(pa), .irq_pin_b(pb), .low_power_mode(lp), .odr_code(odr), .measure_active(ms),
        .sleep_active(sa), .sleep_rate_hz(shz), .act_det_en(ad), .inact_det_en(id), .fifo_write_en(fw),
        .self_test_force(st), .three_wire_mode(tw));

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task complete_run;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // wait for hready, decided on the settled level before the edge
    task rdy;
        int n;
        n = 0;
        @(negedge hclk);
        while (rdyo !== 1'b1 && n < 40) begin
            @(negedge hclk);
            n++;
        end
        if (n >= 40) begin
            fail_count++;
            complete_run;
        end
        @(posedge hclk);
    endtask
    task xfer(input logic wr, input logic [7:0] i, input logic [7:0] w);
        @(posedge hclk);
        {hsel, htrans, hwrite} <= {1'b1, 2'b10, wr};
        haddr <= {22'h0, i, 2'b00};
        rdy;
        {hsel, htrans} <= 3'b000;
        hwdata <= {24'h0, w};
        rdy;
        rd = hrdata;
    endtask
    task rc(input logic [7:0] i, input logic [31:0] e);
        xfer(1'b0, i, 8'h00);
        chk($sformatf("reg %h", i), e, rd);
    endtask
    task cyc(input int n);
        repeat (n) @(negedge hclk);
    endtask
    task pulse(input int b);
        @(posedge hclk);
        stim[b] <= 1'b1;
        @(posedge hclk);
        stim[b] <= 1'b0;
    endtask

    // clock
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, go, fa, fi, htrans, stim, haddr, hwdata} = '0;
        {hsize, raw, fail_count, samples_checked} = {HSIZE_WORD, 13'sd4000, 64'd0};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[k]) begin
            xfer(1'b1, rows[k].i, rows[k].w);
            rc(rows[k].i, {24'h0, rows[k].e});
        end
        xfer(1'b1, IDX_POWER, 8'h00);
        for (int w = 0; w < 4; w++) begin
            xfer(1'b1, IDX_POWER, 8'h08 | w[7:0]);
            cyc(1);
            chk("sleep_rate", 32'(SLEEP_BASE_HZ >> w), 32'(shz));
            chk("measure", 32'h1, 32'(ms));
        end
        xfer(1'b1, IDX_RATE, 8'h1a);
        cyc(1);
        chk("low_power", 32'h1a, {27'h0, lp, odr});
        xfer(1'b1, IDX_FORMAT, 8'hc0);
        cyc(1);
        chk("self_test", 32'h1, 32'(st));
        chk("three_wire", 32'h1, 32'(tw));
        xfer(1'b1, IDX_FORMAT, 8'h00);
        pulse(4);
        cyc(3);
        chk("pin_a", 32'h1, 32'(pa));
        xfer(1'b1, IDX_IRQ_MAP, 8'h10);
        cyc(2);
        chk("pins", 32'h1, {30'h0, pa, pb});
        rc(IDX_CAUSE, 32'h10);
        cyc(2);
        chk("pin_b", 32'h0, 32'(pb));
        xfer(1'b1, IDX_FORMAT, 8'h20);
        cyc(2);
        chk("pin_a_low", 32'h3, {30'h0, pa, pb});
        xfer(1'b1, IDX_FORMAT, 8'h00);
        go <= 1'b1;
        cyc(20);
        pulse(7);
        cyc(60);
        go <= 1'b0;
        rc(IDX_LINK_STATUS, 32'h18);
        pulse(7);
        cyc(2);
        rc(IDX_CAUSE, 32'h80);
        rc(IDX_AXIS_DATA, 32'h1ff);
        rc(IDX_CAUSE, 32'h0);
        {fa, fi} <= 2'b11;
        xfer(1'b1, IDX_POWER, 8'h28);
        pulse(3);
        rc(IDX_LINK_STATUS, 32'h1a);
        pulse(4);
        rc(IDX_LINK_STATUS, 32'h18);
        xfer(1'b1, IDX_POWER, 8'h38);
        pulse(3);
        cyc(2);
        chk("sleep_outs", 32'h0a, {27'h0, hr, sa, fw, ad, id});
        rc(IDX_LINK_STATUS, 32'h1f);
        pulse(4);
        rc(IDX_LINK_STATUS, 32'h18);
        xfer(1'b1, IDX_FORMAT, 8'h0f);
        pulse(7);
        cyc(2);
        rc(IDX_AXIS_DATA, 32'h7d00);
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rc(IDX_RATE, 32'(RATE_RST));
        rc(IDX_POWER, 32'h0);
        complete_run;
    end
endmodule
